// ---- hw/opa_regs.svh ----
// Purpose: register map, field positions and codes of the output phase adjust/align block
// Assumes: AXI4-Lite byte addresses, 32-bit words, three outputs
// Notes:   definitions only
`ifndef OPA_REGS_SVH
`define OPA_REGS_SVH

// ----------------------------------------------------------------
// addresses
// ----------------------------------------------------------------
`define OPA_ADDR_CTRL      8'h00
`define OPA_ADDR_SRC       8'h04
`define OPA_ADDR_STAT      8'h08
`define OPA_PAGE_OCR1      4'h1
`define OPA_PAGE_OPH       4'h2
`define OPA_PAGE_OCR2      4'h3
`define OPA_NUM_OUT        2'd3

// ----------------------------------------------------------------
// phase_ctrl_one fields
// ----------------------------------------------------------------
`define OPA_CTRL_MODE      0
`define OPA_CTRL_ARM       1
`define OPA_CTRL_SOFTWARE_TRIGGER_BIT      2
`define OPA_CTRL_RST       3
`define OPA_CTRL_TRIGGER_INVERT      4
`define OPA_MODE_ALIGN     1'b0

// ----------------------------------------------------------------
// phase_source_select fields and codes
// ----------------------------------------------------------------
`define OPA_SRC_ARM_LSB    0
`define OPA_SRC_TRG_LSB    4
`define OPA_SRC_AGPIO_LSB  8
`define OPA_SRC_TGPIO_LSB  10
`define OPA_ASRC_SW        4'h1
`define OPA_ASRC_APLL      4'h2
`define OPA_ASRC_DPLL      4'h3
`define OPA_ASRC_GPIO      4'h4
`define OPA_TSRC_SW        4'h0
`define OPA_TSRC_APLL      4'h1
`define OPA_TSRC_DPLL      4'h2
`define OPA_TSRC_REFCLK    4'h3
`define OPA_TSRC_GPIO      4'h4

// ----------------------------------------------------------------
// phase_status fields
// ----------------------------------------------------------------
`define OPA_STAT_ARMED     0
`define OPA_STAT_BUSY      1
`define OPA_STAT_DONE      2

// ----------------------------------------------------------------
// per-output fields
// ----------------------------------------------------------------
`define OPA_OCR1_EN        7
`define OPA_OCR2_POL       0
`define OPA_OCR2_FMT_LSB   1
`define OPA_FMT_HSTL       2'h1
`define OPA_FMT_CMOS_PINV  2'h3

// ----------------------------------------------------------------
// reset values, timing, responses
// ----------------------------------------------------------------
`define OPA_RST_CTRL       5'h00
`define OPA_RST_SRC        12'h000
`define OPA_RST_BYTE       8'h00
`define OPA_RST_OCR2       3'h0
`define OPA_BUSY_CYC       3'h4
`define OPA_RESP_OKAY      2'h0
`define OPA_RESP_SLVERR    2'h2

`endif

// ---- hw/opa_pkg.sv ----
// Purpose: types of the output phase adjust/align block
// Assumes: opa_regs.svh holds all numbers
// Notes:   none
package opa_pkg;

	typedef enum logic [1:0] {
		OPA_IDLE,
		OPA_ARMED,
		OPA_APPLY,
		OPA_BUSY
	} opa_state_e;

	// command to one output's medium-speed divider
	typedef struct packed {
		logic       div_reset;
		logic       adjust;
		logic       invert;
		logic [7:0] amount;
	} opa_out_cmd_s;

endpackage

// ---- hw/opa_phase_ctrl.sv ----
// Purpose: arm/trigger controller for output clock phase adjustment and alignment
// Assumes: all inputs synchronous to core_clk_in; AXI4-Lite register access
// Notes:   the dividers themselves sit outside; this block issues their commands
//
// Operation
// - adjust shifts phase from latest in either mode; needs enable bit, nonzero amount.
// - arm source is software arm bit rise, APLL lock, DPLL lock or GPIO.
// - trigger source is trigger bit, APLL lock, DPLL lock, reference clock rise or GPIO.
// - trigger invert flips selected trigger, so one GPIO arms and triggers.
// - arm event waits for the next trigger, which applies the adjustment.
// - one trigger moves all participating outputs, each by its own amount.
// - outputs with medium divide zero never adjust.
// - amount counts half high-speed divider periods.
// - divider alters exactly one period, longer or shorter high time.
// - phase-logic reset cancels pending arm and returns machine to idle.
// - armed and busy are live flags; done is latched.
// - trigger bit is not self-clearing; software clears it when re-arming.
// - alignment mode resets participating dividers just before adjusting.
// - HSTL and inverted-P CMOS outputs are opposite CML unless polarity set.
// - adjustment happens in medium dividers at half-period resolution.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "opa_regs.svh"

module opa_phase_ctrl (
	input  wire logic                         core_clk_in,
	input  wire logic                         rst_b_in,
	input  wire logic [7:0]                   s_axi_awaddr_in,
	input  wire logic                         s_axi_awvalid_in,
	output logic                              s_axi_awready_out,
	input  wire logic [31:0]                  s_axi_wdata_in,
	input  wire logic [3:0]                   s_axi_wstrb_in,
	input  wire logic                         s_axi_wvalid_in,
	output logic                              s_axi_wready_out,
	output logic [1:0]                        s_axi_bresp_out,
	output logic                              s_axi_bvalid_out,
	input  wire logic                         s_axi_bready_in,
	input  wire logic [7:0]                   s_axi_araddr_in,
	input  wire logic                         s_axi_arvalid_in,
	output logic                              s_axi_arready_out,
	output logic [31:0]                       s_axi_rdata_out,
	output logic [1:0]                        s_axi_rresp_out,
	output logic                              s_axi_rvalid_out,
	input  wire logic                         s_axi_rready_in,
	input  wire logic                         apll_lock_in,
	input  wire logic                         dpll_lock_in,
	input  wire logic                         dpll_ref_clk_in,
	input  wire logic [3:0]                   gpio_in,
	output opa_pkg::opa_out_cmd_s [2:0]       out_cmd_out,
	output logic                              armed_out,
	output logic                              busy_out,
	output logic                              adjust_done_out
);
	import opa_pkg::*;

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	function automatic logic opa_mapped(input logic [7:0] a);
		logic page_ok;
		page_ok = (a[7:4] == `OPA_PAGE_OCR1) || (a[7:4] == `OPA_PAGE_OPH) || (a[7:4] == `OPA_PAGE_OCR2);
		opa_mapped = (a[1:0] == 2'h0) &&
			((a == `OPA_ADDR_CTRL) || (a == `OPA_ADDR_SRC) || (a == `OPA_ADDR_STAT) ||
			(page_ok && (a[3:2] < `OPA_NUM_OUT)));
	endfunction

	function automatic logic [31:0] opa_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		opa_merge = m;
	endfunction

	logic [4:0]  phase_ctrl_one;
	logic [11:0] phase_source_select;
	logic        phase_rst;
	logic [7:0]  output_ctrl_one [3];
	logic [7:0]  output_phase_amount_reg [3];
	logic [2:0]  output_ctrl_two [3];
	opa_state_e  state;
	logic [2:0]  busy_cnt;
	logic        arm_prev;
	logic        trg_prev;
	logic        arm_lvl;
	logic        trg_lvl;
	logic        arm_evt;
	logic        trg_evt;
	logic        wr_hs;
	logic [31:0] wr_old;
	logic [31:0] wr_val;
	logic [31:0] rd_val;
	logic        done_set;

	assign wr_hs = s_axi_awready_out && s_axi_awvalid_in;

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= `OPA_RESP_OKAY;
		end else begin
			s_axi_awready_out <= s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_awready_out && !s_axi_bvalid_out;
			s_axi_wready_out  <= s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_awready_out && !s_axi_bvalid_out;
			if (wr_hs) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= opa_mapped(s_axi_awaddr_in) ? `OPA_RESP_OKAY : `OPA_RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	always_comb begin
		wr_old = 32'h0;
		case (s_axi_awaddr_in[7:4])
			4'h0:           wr_old = (s_axi_awaddr_in == `OPA_ADDR_SRC) ? {20'h0, phase_source_select} :
				(s_axi_awaddr_in == `OPA_ADDR_CTRL) ? {27'h0, phase_ctrl_one} : 32'h0;
			`OPA_PAGE_OCR1: wr_old = {24'h0, output_ctrl_one[s_axi_awaddr_in[3:2]]};
			`OPA_PAGE_OPH:  wr_old = {24'h0, output_phase_amount_reg[s_axi_awaddr_in[3:2]]};
			`OPA_PAGE_OCR2: wr_old = {29'h0, output_ctrl_two[s_axi_awaddr_in[3:2]]};
			default:        wr_old = 32'h0;
		endcase
		wr_val = opa_merge(wr_old, s_axi_wdata_in, s_axi_wstrb_in);
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_ctrl_one      <= `OPA_RST_CTRL;
			phase_source_select <= `OPA_RST_SRC;
			phase_rst           <= 1'b0;
		end else begin
			phase_rst <= 1'b0;
			if (wr_hs && (s_axi_awaddr_in == `OPA_ADDR_CTRL)) begin
				// trigger bit stays as written; software clears it itself
				phase_ctrl_one <= wr_val[4:0] & ~(5'h1 << `OPA_CTRL_RST);
				phase_rst      <= wr_val[`OPA_CTRL_RST];
			end
			if (wr_hs && (s_axi_awaddr_in == `OPA_ADDR_SRC)) begin
				phase_source_select <= wr_val[11:0];
			end
		end
	end

	generate
		for (genvar gk = 0; gk < 3; gk++) begin : g_out_reg
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					output_ctrl_one[gk]         <= `OPA_RST_BYTE;
					output_phase_amount_reg[gk] <= `OPA_RST_BYTE;
					output_ctrl_two[gk]         <= `OPA_RST_OCR2;
				end else if (wr_hs && opa_mapped(s_axi_awaddr_in) && (s_axi_awaddr_in[3:2] == 2'(gk))) begin
					case (s_axi_awaddr_in[7:4])
						`OPA_PAGE_OCR1: output_ctrl_one[gk]         <= wr_val[7:0];
						`OPA_PAGE_OPH:  output_phase_amount_reg[gk] <= wr_val[7:0];
						`OPA_PAGE_OCR2: output_ctrl_two[gk]         <= wr_val[2:0];
						default:        output_ctrl_one[gk]         <= output_ctrl_one[gk];
					endcase
				end
			end
		end
	endgenerate

	always_comb begin
		rd_val = 32'h0;
		case (s_axi_araddr_in[7:4])
			4'h0:           rd_val = (s_axi_araddr_in == `OPA_ADDR_CTRL) ? {27'h0, phase_ctrl_one} :
				(s_axi_araddr_in == `OPA_ADDR_SRC) ? {20'h0, phase_source_select} :
				{29'h0, adjust_done_out, busy_out, armed_out};
			`OPA_PAGE_OCR1: rd_val = {24'h0, output_ctrl_one[s_axi_araddr_in[3:2]]};
			`OPA_PAGE_OPH:  rd_val = {24'h0, output_phase_amount_reg[s_axi_araddr_in[3:2]]};
			`OPA_PAGE_OCR2: rd_val = {29'h0, output_ctrl_two[s_axi_araddr_in[3:2]]};
			default:        rd_val = 32'h0;
		endcase
		if (!opa_mapped(s_axi_araddr_in)) begin
			rd_val = 32'h0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0;
			s_axi_rresp_out   <= `OPA_RESP_OKAY;
		end else begin
			s_axi_arready_out <= s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out;
			if (s_axi_arready_out && s_axi_arvalid_in) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out  <= rd_val;
				s_axi_rresp_out  <= opa_mapped(s_axi_araddr_in) ? `OPA_RESP_OKAY : `OPA_RESP_SLVERR;
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// arm and trigger sources
	// ----------------------------------------------------------------
	always_comb begin
		case (phase_source_select[`OPA_SRC_ARM_LSB +: 4])
			`OPA_ASRC_SW:   arm_lvl = phase_ctrl_one[`OPA_CTRL_ARM];
			`OPA_ASRC_APLL: arm_lvl = apll_lock_in;
			`OPA_ASRC_DPLL: arm_lvl = dpll_lock_in;
			`OPA_ASRC_GPIO: arm_lvl = gpio_in[phase_source_select[`OPA_SRC_AGPIO_LSB +: 2]];
			default:        arm_lvl = 1'b0;
		endcase
		case (phase_source_select[`OPA_SRC_TRG_LSB +: 4])
			`OPA_TSRC_SW:     trg_lvl = phase_ctrl_one[`OPA_CTRL_SOFTWARE_TRIGGER_BIT];
			`OPA_TSRC_APLL:   trg_lvl = apll_lock_in;
			`OPA_TSRC_DPLL:   trg_lvl = dpll_lock_in;
			`OPA_TSRC_REFCLK: trg_lvl = dpll_ref_clk_in;
			`OPA_TSRC_GPIO:   trg_lvl = gpio_in[phase_source_select[`OPA_SRC_TGPIO_LSB +: 2]];
			default:          trg_lvl = 1'b0;
		endcase
		trg_lvl = trg_lvl ^ phase_ctrl_one[`OPA_CTRL_TRIGGER_INVERT];
		arm_evt = arm_lvl && !arm_prev;
		trg_evt = trg_lvl && !trg_prev;
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arm_prev <= 1'b0;
			trg_prev <= 1'b0;
		end else begin
			arm_prev <= arm_lvl;
			trg_prev <= trg_lvl;
		end
	end

	// ----------------------------------------------------------------
	// adjust/align state machine
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state    <= OPA_IDLE;
			busy_cnt <= 3'h0;
		end else if (phase_rst) begin
			state    <= OPA_IDLE;
			busy_cnt <= 3'h0;
		end else begin
			case (state)
				OPA_IDLE: begin
					if (arm_evt) begin
						state <= OPA_ARMED;
					end
				end
				OPA_ARMED: begin
					if (trg_evt) begin
						state <= OPA_APPLY;
					end
				end
				OPA_APPLY: begin
					state    <= OPA_BUSY;
					busy_cnt <= `OPA_BUSY_CYC - 3'h1;
				end
				OPA_BUSY: begin
					if (busy_cnt == 3'h0) begin
						state <= OPA_IDLE;
					end else begin
						busy_cnt <= busy_cnt - 3'h1;
					end
				end
				default: state <= OPA_IDLE;
			endcase
		end
	end

	assign done_set = (state == OPA_BUSY) && (busy_cnt == 3'h0) && !phase_rst;

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			armed_out       <= 1'b0;
			busy_out        <= 1'b0;
			adjust_done_out <= 1'b0;
		end else begin
			armed_out <= !phase_rst && (((state == OPA_IDLE) && arm_evt) ||
				((state == OPA_ARMED) && !trg_evt));
			busy_out  <= !phase_rst && (((state == OPA_ARMED) && trg_evt) || (state == OPA_APPLY) ||
				((state == OPA_BUSY) && (busy_cnt != 3'h0)));
			// a completion in the clearing cycle wins
			if (done_set) begin
				adjust_done_out <= 1'b1;
			end else if (wr_hs && (s_axi_awaddr_in == `OPA_ADDR_STAT) && wr_val[`OPA_STAT_DONE]) begin
				adjust_done_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// per-output divider commands
	// ----------------------------------------------------------------
	generate
		for (genvar gk = 0; gk < 3; gk++) begin : g_out_cmd
			logic part;
			logic [1:0] fmt;
			assign part = output_ctrl_one[gk][`OPA_OCR1_EN] && (output_ctrl_one[gk][6:0] != 7'h0);
			assign fmt  = output_ctrl_two[gk][`OPA_OCR2_FMT_LSB +: 2];
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					out_cmd_out[gk] <= '0;
				end else begin
					// dividers reset one cycle ahead of the adjust pulse
					out_cmd_out[gk].div_reset <= (state == OPA_ARMED) && trg_evt && !phase_rst && part &&
						(phase_ctrl_one[`OPA_CTRL_MODE] == `OPA_MODE_ALIGN);
					out_cmd_out[gk].adjust <= (state == OPA_APPLY) && !phase_rst && part &&
						(output_phase_amount_reg[gk] != 8'h0);
					out_cmd_out[gk].amount <= output_phase_amount_reg[gk];
					out_cmd_out[gk].invert <= output_ctrl_two[gk][`OPA_OCR2_POL] ^
						((fmt == `OPA_FMT_HSTL) || (fmt == `OPA_FMT_CMOS_PINV));
				end
			end
		end
	endgenerate

endmodule

// ---- tb/opa_phase_ctrl_chk.sv ----
// Purpose: assertions on the phase sequencing outputs
// Assumes: busy lasts 5 cycles, adjust falls in its second cycle
// Notes:   bound to opa_phase_ctrl
`timescale 1ns/1ps
module opa_phase_chk (
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_b_in,
	input  wire opa_pkg::opa_out_cmd_s [2:0] out_cmd_out,
	input  wire logic                        s_axi_bvalid_out,
	input  wire logic                        armed_out,
	input  wire logic                        busy_out,
	input  wire logic                        adjust_done_out
);
	import opa_pkg::*;
	logic [2:0] adj;
	logic [2:0] drs;
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			adj[k] = out_cmd_out[k].adjust;
			drs[k] = out_cmd_out[k].div_reset;
		end
	end
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// ------------------------------------------------
	// sequencing
	// ------------------------------------------------
	property p_adj_in_busy;
		|adj |-> busy_out && $past(busy_out) && !$past(busy_out, 2);
	endproperty
	a_adj_in_busy: assert property (p_adj_in_busy) else $error("adjust outside second busy cycle");
	property p_busy_len;
		$rose(busy_out) |-> busy_out[*5] ##1 !busy_out;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_busy_from_arm;
		$rose(busy_out) |-> $past(armed_out) && !armed_out;
	endproperty
	a_busy_from_arm: assert property (p_busy_from_arm) else $error("busy without armed");
	property p_done_rise;
		$rose(adjust_done_out) |-> $past(busy_out) && !busy_out;
	endproperty
	a_done_rise: assert property (p_done_rise) else $error("done not at busy end");
	property p_done_after;
		$fell(busy_out) |-> adjust_done_out;
	endproperty
	a_done_after: assert property (p_done_after) else $error("done missing after busy");
	property p_excl;
		!(armed_out && busy_out);
	endproperty
	a_excl: assert property (p_excl) else $error("armed and busy together");
	property p_drs;
		|drs |-> $rose(busy_out);
	endproperty
	a_drs: assert property (p_drs) else $error("divider reset off trigger");
	property p_adj_pulse;
		|adj |=> !(|adj);
	endproperty
	a_adj_pulse: assert property (p_adj_pulse) else $error("adjust longer than one cycle");
	property p_done_hold;
		$fell(adjust_done_out) |-> $rose(s_axi_bvalid_out);
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("done cleared without write");
	c_busy: cover property ($rose(busy_out));
	c_drs: cover property (|drs);
	c_done: cover property ($fell(adjust_done_out));
endmodule
bind opa_phase_ctrl opa_phase_chk u_chk (
	.core_clk_in      (core_clk_in),
	.rst_b_in         (rst_b_in),
	.out_cmd_out      (out_cmd_out),
	.s_axi_bvalid_out (s_axi_bvalid_out),
	.armed_out        (armed_out),
	.busy_out         (busy_out),
	.adjust_done_out  (adjust_done_out)
);

// ---- tb/opa_clk_sink.sv ----
// Purpose: receiver side of the output dividers, counts divider resets
// Assumes: commands are one-cycle pulses
// Notes:   counts wrap at 8 bits
`timescale 1ns/1ps
module opa_clk_sink (
	input  wire logic                        core_clk_in,
	input  wire logic                        rst_b_in,
	input  wire opa_pkg::opa_out_cmd_s [2:0] cmd_in,
	output logic [2:0][7:0]                  rst_cnt_out
);
	import opa_pkg::*;
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_cnt_out <= '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				rst_cnt_out[k] <= rst_cnt_out[k] + 8'(cmd_in[k].div_reset);
			end
		end
	end
endmodule

// ---- tb/output_clock_phase_adjust_align_tb.sv ----
// Purpose: self-checking bench of the phase adjust/align controller
// Assumes: AXI4-Lite master, lock, gpio and reference stimulus
// Notes:   read, write and adjust results checked through queues
`timescale 1ns/1ps
`include "opa_regs.svh"
module output_clock_phase_adjust_align_tb;
	import opa_pkg::*;
	logic               core_clk_in, rst_b_in, awv, wv, bre, arv, rre, md;
	logic               awr, wrd, bv, arr, rv, armed, busy, done;
	logic [7:0]         awa, ara, a0, a1, a2, r0, r2;
	logic [31:0]        wd, rdat;
	logic [1:0]         bresp, rresp, gi;
	logic [4:0]         lv;
	logic [3:0]         gpio, as, ts;
	logic [2:0]         st, adj;
	logic [6:0]         d0;
	opa_out_cmd_s [2:0] cmd;
	logic [2:0][7:0]    rcnt;
	logic [33:0]        qr[$], qb[$], qa[$];
	int                 err_count, samples_checked, cyc;
	assign st = {done, busy, armed};
	assign adj = {cmd[2].adjust, cmd[1].adjust, cmd[0].adjust};
	assign gpio = {4{~lv[4]}} ^ (4'h1 << gi);
	always #12.5 core_clk_in = ~core_clk_in;
	opa_phase_ctrl uut (
		.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
		.s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
		.s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
		.s_axi_wready_out(wrd), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv),
		.s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
		.s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .apll_lock_in(lv[1]),
		.dpll_lock_in(lv[2]), .dpll_ref_clk_in(lv[3]), .gpio_in(gpio),
		.out_cmd_out(cmd), .armed_out(armed), .busy_out(busy), .adjust_done_out(done)
	);
	opa_clk_sink sink (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .cmd_in(cmd), .rst_cnt_out(rcnt));
	// ------------------------------------------------
	// checking
	// ------------------------------------------------
	task automatic cmp(input logic [33:0] e, input logic [33:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task automatic take(ref logic [33:0] q[$], input logic [33:0] g);
		cmp(q.size() > 0 ? q.pop_front() : ~g, g);
	endtask
	always @(negedge core_clk_in) begin
		if (rv === 1'b1 && rre === 1'b1) take(qr, {rresp, rdat});
		if (bv === 1'b1 && bre === 1'b1) take(qb, {bresp, 32'h0});
		if (adj !== 3'h0) take(qa, {7'h0, adj, cmd[2].amount, cmd[1].amount, cmd[0].amount});
	end
	task automatic give_verdict();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	// ------------------------------------------------
	// drivers
	// ------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = `OPA_RESP_OKAY);
		qb.push_back({r, 32'h0});
		@(posedge core_clk_in);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		do @(posedge core_clk_in); while (awr !== 1'b1 || wrd !== 1'b1);
		awv <= 1'b0;
		wv <= 1'b0;
		do @(posedge core_clk_in); while (bv !== 1'b1);
		bre <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		qr.push_back(e);
		@(posedge core_clk_in);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do @(posedge core_clk_in); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge core_clk_in); while (rv !== 1'b1);
		rre <= 1'b0;
	endtask
	task automatic kick(input int s);
		@(posedge core_clk_in);
		lv[s] <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		lv[s] <= 1'b1;
		repeat (3) @(posedge core_clk_in);
	endtask
	task automatic wait_st(input int w, input logic v);
		int n;
		n = 0;
		while (st[w] !== v && n < 60) begin
			@(posedge core_clk_in);
			n++;
		end
		cmp({33'h0, v}, {33'h0, st[w]});
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	initial begin
		core_clk_in = 1'b0;
		rst_b_in = 1'b0;
		{awv, wv, bre, arv, rre, awa, ara, wd, lv, gi} = '0;
		void'($urandom(7333));
		repeat (4) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		rd(8'h00, 34'h0);
		rd(8'h08, 34'h0);
		rd(8'h3c, {`OPA_RESP_SLVERR, 32'h0});
		wr(8'h3c, 32'h1, `OPA_RESP_SLVERR);
		for (int f = 0; f < 8; f++) begin
			wr(8'h38, 32'(f));
			repeat (2) @(posedge core_clk_in);
			cmp(34'(f[0] ^ (f[2:1] == 2'h1 || f[2:1] == 2'h3)), 34'(cmd[2].invert));
		end
		for (int i = 0; i < 5; i++) begin
			as = 4'((i % 4) + 1);
			ts = 4'(i);
			md = (i != 1);
			gi <= 2'(i);
			d0 = 7'($urandom_range(125, 1));
			a0 = 8'($urandom_range(127 - d0, 1));
			a1 = 8'($urandom_range(255, 128));
			a2 = 8'($urandom_range(255, 1));
			wr(8'h10, {24'h0, 1'b1, d0});
			wr(8'h14, 32'h80);
			wr(8'h18, {24'h0, 1'b0, d0});
			wr(8'h20, {24'h0, a0});
			wr(8'h24, {24'h0, a1});
			wr(8'h28, {24'h0, a2});
			wr(8'h04, {20'h0, 2'(i), 2'(i), ts, as});
			wr(8'h00, {27'h0, 4'h4, md});
			wr(8'h00, {31'h0, md});
			r0 = rcnt[0];
			r2 = rcnt[2];
			if (as == 4'h1) wr(8'h00, {30'h0, 1'b1, md});
			else kick((as == 4'h4) ? 4 : int'(as) - 1);
			wait_st(0, 1'b1);
			qa.push_back({7'h0, 3'b001, a2, a1, a0});
			if (ts == 4'h0) wr(8'h00, {29'h0, 2'h3, md});
			else kick(int'(ts));
			wait_st(2, 1'b1);
			cmp({18'h0, r0 + 8'(!md), r2}, {18'h0, rcnt[0], rcnt[2]});
			rd(8'h08, 34'h4);
			wr(8'h08, 32'h4);
			rd(8'h08, 34'h0);
		end
		wr(8'h04, 32'h1);
		wr(8'h00, 32'h9);
		wr(8'h00, 32'h5);
		repeat (8) @(posedge core_clk_in);
		cmp(34'h0, {31'h0, st});
		wr(8'h00, 32'h3);
		wait_st(0, 1'b1);
		wr(8'h00, 32'h9);
		wait_st(0, 1'b0);
		wr(8'h00, 32'h5);
		repeat (8) @(posedge core_clk_in);
		rd(8'h08, 34'h0);
		@(posedge core_clk_in);
		gi <= 2'h1;
		lv[4] <= 1'b0;
		wr(8'h04, 32'h544);
		wr(8'h00, 32'h19);
		wr(8'h00, 32'h11);
		@(posedge core_clk_in);
		lv[4] <= 1'b1;
		wait_st(0, 1'b1);
		qa.push_back({7'h0, 3'b001, a2, a1, a0});
		@(posedge core_clk_in);
		lv[4] <= 1'b0;
		wait_st(2, 1'b1);
		give_verdict();
	end
endmodule
